// file: logic/gia_top.sv
// global interrupt aggregator: per-source level status, enables, one irq line
// assumes source levels arrive unsynchronised; host reaches registers over axi4-lite
//
// Contract
// - framer 1..4 status bits follow their lines
// - framer status register; bit 3 is framer 4
// - tester status bits 3..0 follow tester lines
// - line unit status bits follow unit lines
// - hdlc status read-only, bits follow controller lines
// - framer enable bits 3..0, reset zero
// - tester enable bits 3..0, reset zero
// - line unit enable bits 3..0, reset zero
// - hdlc enable read/write, reset zero

`timescale 1ns/1ps

module gia_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // interrupt sources, one per channel
  input wire logic [3:0] FRAMER_IRQ_I,
  input wire logic [3:0] TESTER_IRQ_I,
  input wire logic [3:0] LINE_UNIT_IRQ_I,
  input wire logic [3:0] HDLC_IRQ_I,
  // interrupt to host
  output logic IRQ_O,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  initial
  begin
    if (ADDR_W < gia_pkg::IDX_W + gia_pkg::ADDR_LSB)
    begin
      $error("gia_top: ADDR_W too small to reach the register indices");
    end
  end

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [15:0] src_raw;
  logic [15:0] src_sync;
  logic [15:0] status_ff;
  logic [15:0] src_prev_ff;
  logic [15:0] edge_ff;
  logic [15:0] nxt_edge;
  logic [15:0] edge_en_ff;
  logic [3:0] enable_ff [gia_pkg::NUM_GRP];
  logic [15:0] enable_flat;
  logic [15:0] edge_clr;
  logic irq_ff;
  logic nxt_irq;

  logic aw_got_ff;
  logic nxt_aw_got;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic w_got_ff;
  logic nxt_w_got;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic do_write;
  logic [7:0] wr_idx;
  logic wr_hit;
  logic wr_lane0;

  logic arready_ff;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_take;
  logic [7:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_hit;

  // ==========================================================================
  // source capture
  // ==========================================================================
  // group order in every 16-bit vector: framer, tester, line unit, hdlc
  assign src_raw = {HDLC_IRQ_I, LINE_UNIT_IRQ_I, TESTER_IRQ_I, FRAMER_IRQ_I};

  gia_sync #(
    .WIDTH(16)
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .async_i(src_raw),
    .sync_o(src_sync)
  );

  // status is a plain copy of the source level, never latched
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      status_ff <= 16'h0000;
    end
    else
    begin
      status_ff <= src_sync;
    end
  end

  // ==========================================================================
  // sticky edge capture, write one to clear
  // ==========================================================================
  // catches a source pulse too short to be seen by polling the level status
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      src_prev_ff <= 16'h0000;
    end
    else
    begin
      src_prev_ff <= src_sync;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_edge
      // a new edge in the clearing cycle survives the clear
      assign nxt_edge[g] = (src_sync[g] & ~src_prev_ff[g]) | (edge_ff[g] & ~edge_clr[g]);
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      edge_ff <= gia_pkg::EDGE_RST;
    end
    else
    begin
      edge_ff <= nxt_edge;
    end
  end

  // ==========================================================================
  // write channel
  // ==========================================================================
  // address and data are taken in either order; one write is in flight at a time
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign nxt_aw_got = aw_got_ff ? !do_write : (S_AXI_AWVALID_I && awready_ff);
  assign nxt_w_got = w_got_ff ? !do_write : (S_AXI_WVALID_I && wready_ff);
  assign nxt_bvalid = bvalid_ff ? !S_AXI_BREADY_I : do_write;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_addr_ff <= '0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_I && awready_ff)
      begin
        aw_addr_ff <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready_ff)
      begin
        w_data_ff <= S_AXI_WDATA_I;
        w_strb_ff <= S_AXI_WSTRB_I;
      end
    end
  end

  // ==========================================================================
  // write decode
  // ==========================================================================
  assign wr_idx = aw_addr_ff[gia_pkg::ADDR_LSB +: gia_pkg::IDX_W];
  assign wr_lane0 = w_strb_ff[0];

  always_comb
  begin
    wr_hit = 1'b1;
    if (aw_addr_ff >> (gia_pkg::ADDR_LSB + gia_pkg::IDX_W) != '0)
    begin
      wr_hit = 1'b0;
    end
    else if (wr_idx == gia_pkg::FRAMER_IRQ_STATUS_IDX || wr_idx == gia_pkg::TESTER_IRQ_STATUS_IDX)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_idx == gia_pkg::LINE_UNIT_IRQ_STATUS_IDX || wr_idx == gia_pkg::HDLC_IRQ_STATUS_IDX)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_idx == gia_pkg::FRAMER_IRQ_ENABLE_IDX || wr_idx == gia_pkg::TESTER_IRQ_ENABLE_IDX)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_idx == gia_pkg::LINE_UNIT_IRQ_ENABLE_IDX || wr_idx == gia_pkg::HDLC_IRQ_ENABLE_IDX)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_idx == gia_pkg::EDGE_IRQ_STATUS_IDX || wr_idx == gia_pkg::EDGE_IRQ_ENABLE_IDX)
    begin
      wr_hit = 1'b1;
    end
    else
    begin
      wr_hit = 1'b0;
    end
  end

  // edge bits span byte lanes 0 and 1
  assign edge_clr = (do_write && wr_hit && wr_idx == gia_pkg::EDGE_IRQ_STATUS_IDX)
                  ? (w_data_ff[15:0] & {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}}) : 16'h0000;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      bresp_ff <= gia_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bresp_ff <= wr_hit ? gia_pkg::RESP_OKAY : gia_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================================
  // enable registers
  // ==========================================================================
  // group enables store bits 3..0 and the edge enable bits 15..0; writes to other bits and to the group status registers are dropped
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      for (int i = 0; i < gia_pkg::NUM_GRP; i++)
      begin
        enable_ff[i] <= gia_pkg::ENABLE_RST;
      end
      edge_en_ff <= gia_pkg::EDGE_RST;
    end
    else if (do_write && wr_hit)
    begin
      if (wr_lane0 && wr_idx == gia_pkg::FRAMER_IRQ_ENABLE_IDX)
      begin
        enable_ff[gia_pkg::GRP_FRAMER] <= w_data_ff[3:0];
      end
      else if (wr_lane0 && wr_idx == gia_pkg::TESTER_IRQ_ENABLE_IDX)
      begin
        enable_ff[gia_pkg::GRP_TESTER] <= w_data_ff[3:0];
      end
      else if (wr_lane0 && wr_idx == gia_pkg::LINE_UNIT_IRQ_ENABLE_IDX)
      begin
        enable_ff[gia_pkg::GRP_LINE_UNIT] <= w_data_ff[3:0];
      end
      else if (wr_lane0 && wr_idx == gia_pkg::HDLC_IRQ_ENABLE_IDX)
      begin
        enable_ff[gia_pkg::GRP_HDLC] <= w_data_ff[3:0];
      end
      else if (wr_idx == gia_pkg::EDGE_IRQ_ENABLE_IDX)
      begin
        if (w_strb_ff[0])
        begin
          edge_en_ff[7:0] <= w_data_ff[7:0];
        end
        if (w_strb_ff[1])
        begin
          edge_en_ff[15:8] <= w_data_ff[15:8];
        end
      end
    end
  end

  assign enable_flat = {enable_ff[3], enable_ff[2], enable_ff[1], enable_ff[0]};

  // ==========================================================================
  // interrupt output
  // ==========================================================================
  // edge enables reset to zero, so out of reset the line follows the levels only
  assign nxt_irq = (|(src_sync & enable_flat)) | (|(nxt_edge & edge_en_ff));

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================================
  // read channel
  // ==========================================================================
  assign ar_take = S_AXI_ARVALID_I && arready_ff;
  assign nxt_rvalid = rvalid_ff ? !S_AXI_RREADY_I : ar_take;
  assign rd_idx = S_AXI_ARADDR_I[gia_pkg::ADDR_LSB +: gia_pkg::IDX_W];

  always_comb
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR_I >> (gia_pkg::ADDR_LSB + gia_pkg::IDX_W) != '0)
    begin
      rd_hit = 1'b0;
    end
    else if (rd_idx == gia_pkg::FRAMER_IRQ_STATUS_IDX)
    begin
      rd_word[3:0] = status_ff[3:0];
    end
    else if (rd_idx == gia_pkg::TESTER_IRQ_STATUS_IDX)
    begin
      rd_word[3:0] = status_ff[7:4];
    end
    else if (rd_idx == gia_pkg::LINE_UNIT_IRQ_STATUS_IDX)
    begin
      rd_word[3:0] = status_ff[11:8];
    end
    else if (rd_idx == gia_pkg::HDLC_IRQ_STATUS_IDX)
    begin
      rd_word[3:0] = status_ff[15:12];
    end
    else if (rd_idx == gia_pkg::FRAMER_IRQ_ENABLE_IDX)
    begin
      rd_word[3:0] = enable_ff[gia_pkg::GRP_FRAMER];
    end
    else if (rd_idx == gia_pkg::TESTER_IRQ_ENABLE_IDX)
    begin
      rd_word[3:0] = enable_ff[gia_pkg::GRP_TESTER];
    end
    else if (rd_idx == gia_pkg::LINE_UNIT_IRQ_ENABLE_IDX)
    begin
      rd_word[3:0] = enable_ff[gia_pkg::GRP_LINE_UNIT];
    end
    else if (rd_idx == gia_pkg::HDLC_IRQ_ENABLE_IDX)
    begin
      rd_word[3:0] = enable_ff[gia_pkg::GRP_HDLC];
    end
    else if (rd_idx == gia_pkg::EDGE_IRQ_STATUS_IDX)
    begin
      rd_word[15:0] = edge_ff;
    end
    else if (rd_idx == gia_pkg::EDGE_IRQ_ENABLE_IDX)
    begin
      rd_word[15:0] = edge_en_ff;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= gia_pkg::RESP_OKAY;
    end
    else
    begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? gia_pkg::RESP_OKAY : gia_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign IRQ_O = irq_ff;
  assign S_AXI_AWREADY_O = awready_ff;
  assign S_AXI_WREADY_O = wready_ff;
  assign S_AXI_BVALID_O = bvalid_ff;
  assign S_AXI_BRESP_O = bresp_ff;
  assign S_AXI_ARREADY_O = arready_ff;
  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RDATA_O = rdata_ff;
  assign S_AXI_RRESP_O = rresp_ff;

endmodule : gia_top

// file: pkg/gia_pkg.sv
// global interrupt aggregator: register indices, reset values, field layout
// assumes a 32-bit axi4-lite register bus; byte address is four times the index

package gia_pkg;

  // ==========================================================================
  // bus geometry
  // ==========================================================================
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int ADDR_LSB = 2;
  localparam int NUM_CH = 4;
  localparam int NUM_GRP = 4;

  // ==========================================================================
  // register indices as printed; byte address = index * 4
  // ==========================================================================
  localparam logic [7:0] HDLC_IRQ_STATUS_IDX = 8'hF5;
  localparam logic [7:0] HDLC_IRQ_ENABLE_IDX = 8'hF7;
  localparam logic [7:0] FRAMER_IRQ_STATUS_IDX = 8'hF9;
  localparam logic [7:0] TESTER_IRQ_STATUS_IDX = 8'hFA;
  localparam logic [7:0] LINE_UNIT_IRQ_STATUS_IDX = 8'hFB;
  localparam logic [7:0] FRAMER_IRQ_ENABLE_IDX = 8'hFC;
  localparam logic [7:0] TESTER_IRQ_ENABLE_IDX = 8'hFD;
  localparam logic [7:0] LINE_UNIT_IRQ_ENABLE_IDX = 8'hFE;
  // sticky rising-edge capture of all sixteen sources and its enable
  localparam logic [7:0] EDGE_IRQ_STATUS_IDX = 8'hE0;
  localparam logic [7:0] EDGE_IRQ_ENABLE_IDX = 8'hE1;

  // ==========================================================================
  // reset values and field layout
  // ==========================================================================
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [15:0] EDGE_RST = 16'h0000;
  localparam int GRP_FRAMER = 0;
  localparam int GRP_TESTER = 1;
  localparam int GRP_LINE_UNIT = 2;
  localparam int GRP_HDLC = 3;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // axi response codes
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gia_pkg

// file: logic/gia_sync.sv
// two-flop level synchroniser for a bus of independent levels
// assumes each bit is a slow level; multi-bit coherence is not needed

`timescale 1ns/1ps

module gia_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("gia_sync: WIDTH must be at least 1");
    end
  end

  // first stage is read only by the second stage
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : gia_sync

// file: bench/gia_properties.sv
// checker: bus and interrupt relations at the aggregator's ports
// assumes it is bound into gia_top and no enabled edge flag stands while all sources are low
`timescale 1ns/1ps

module gia_properties #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // sources and interrupt
  input wire logic [3:0] FRAMER_IRQ_I,
  input wire logic [3:0] TESTER_IRQ_I,
  input wire logic [3:0] LINE_UNIT_IRQ_I,
  input wire logic [3:0] HDLC_IRQ_I,
  input wire logic IRQ_O,
  // register bus
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  localparam logic [ADDR_W-1:0] FR_ADDR = ADDR_W'({gia_pkg::FRAMER_IRQ_STATUS_IDX, 2'b00});
  // ==========================================================================
  // helpers
  // ==========================================================================
  logic wrote_ff;
  logic [ADDR_W-1:0] rd_addr_ff;
  wire logic ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire logic quiet = ~|{FRAMER_IRQ_I, TESTER_IRQ_I, LINE_UNIT_IRQ_I, HDLC_IRQ_I};
  // set on address acceptance so a slow bready can never race the irq
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    if (!RESET_N_I)
      wrote_ff <= 1'b0;
    else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      wrote_ff <= 1'b1;
  always_ff @(posedge CLK_SYS_I)
    if (ar_hs)
      rd_addr_ff <= S_AXI_ARADDR_I;
  sequence framer_steady;
    $stable(FRAMER_IRQ_I) [*4];
  endsequence
  // ==========================================================================
  // assertions
  // ==========================================================================
  chk_irq_before_write: assert property (!wrote_ff |-> !IRQ_O)
    else $error("irq raised while all enables hold reset value");
  chk_irq_no_source: assert property (quiet [*4] |-> !IRQ_O)
    else $error("irq high with every source low");
  chk_read_answer: assert property (ar_hs |=> S_AXI_RVALID_O)
    else $error("read not answered one cycle after address");
  chk_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped before rready");
  chk_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
    else $error("write response dropped before bready");
  chk_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
    |-> ##2 S_AXI_BVALID_O)
    else $error("write response late");
  chk_upper_zero: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == gia_pkg::RESP_OKAY
    && (rd_addr_ff >> 6) == ADDR_W'(15) |-> S_AXI_RDATA_O[31:4] == 28'h0)
    else $error("upper read bits not zero");
  chk_status_live: assert property (framer_steady ##0 (ar_hs && S_AXI_ARADDR_I == FR_ADDR)
    |=> S_AXI_RDATA_O[3:0] == $past(FRAMER_IRQ_I))
    else $error("framer status differs from source levels");
  cover property (ar_hs && S_AXI_ARADDR_I == FR_ADDR);
  cover property ($rose(IRQ_O));
  cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
endmodule : gia_properties

bind gia_top gia_properties #(.ADDR_W(ADDR_W)) chk (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .FRAMER_IRQ_I(FRAMER_IRQ_I), .TESTER_IRQ_I(TESTER_IRQ_I),
  .LINE_UNIT_IRQ_I(LINE_UNIT_IRQ_I), .HDLC_IRQ_I(HDLC_IRQ_I), .IRQ_O(IRQ_O),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I)
);

// file: bench/gia_host.sv
// host model: axi4-lite master doing single reads and writes
// assumes one clock; tasks are called one at a time from the bench
`timescale 1ns/1ps

module gia_host #(
  parameter int ADDR_W = 12
) (
  // clock
  input wire logic clk_i,
  // write side
  output logic [ADDR_W-1:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // read side
  output logic [ADDR_W-1:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial
  begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // released payloads are inverted so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= dat;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!done)
    begin
      @(posedge clk_i);
      if (awvalid_o && awready_i)
      begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i)
      begin
        wvalid_o <= 1'b0;
        wdata_o <= ~dat;
      end
      if (bready_o && bvalid_i)
      begin
        resp = bresp_i;
        bready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (!done)
    begin
      @(posedge clk_i);
      if (arvalid_o && arready_i)
      begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rready_o && rvalid_i)
      begin
        dat = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
endmodule : gia_host

// file: bench/test_global_interrupt_aggregator.sv
// bench: drives source levels and reaches the registers through the host model
// assumes gia_top at its default address width
`timescale 1ns/1ps

module test_global_interrupt_aggregator;
  typedef struct packed {logic [15:0] src; logic [15:0] en; logic irq;} gia_row_t;
  logic clk_sys, reset_n, irq;
  logic [15:0] src;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int bad_count, cmp_count, cyc;
  logic [7:0] sts_idx [4] = '{gia_pkg::FRAMER_IRQ_STATUS_IDX, gia_pkg::TESTER_IRQ_STATUS_IDX,
    gia_pkg::LINE_UNIT_IRQ_STATUS_IDX, gia_pkg::HDLC_IRQ_STATUS_IDX};
  logic [7:0] en_idx [4] = '{gia_pkg::FRAMER_IRQ_ENABLE_IDX, gia_pkg::TESTER_IRQ_ENABLE_IDX,
    gia_pkg::LINE_UNIT_IRQ_ENABLE_IDX, gia_pkg::HDLC_IRQ_ENABLE_IDX};
  // nibbles: framer, tester, line unit, hdlc from the bottom
  gia_row_t rows [9] = '{'{16'h0000, 16'hFFFF, 1'b0}, '{16'h0001, 16'h0001, 1'b1},
    '{16'h0008, 16'h0007, 1'b0}, '{16'h0008, 16'h0008, 1'b1}, '{16'h00A0, 16'h0020, 1'b1},
    '{16'h0500, 16'h0A00, 1'b0}, '{16'h0400, 16'h0400, 1'b1}, '{16'hF000, 16'h8000, 1'b1},
    '{16'h6000, 16'h9FFF, 1'b0}};

  gia_top uut (
    .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .FRAMER_IRQ_I(src[3:0]), .TESTER_IRQ_I(src[7:4]),
    .LINE_UNIT_IRQ_I(src[11:8]), .HDLC_IRQ_I(src[15:12]), .IRQ_O(irq),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
  );
  gia_host host (
    .clk_i(clk_sys), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready)
  );
  // ==========================================================================
  // clock, timeout, checks
  // ==========================================================================
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : adr
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_flag
  task automatic rd_chk(input logic [7:0] idx, input logic [3:0] exp);
    host.rd(adr(idx), d, r);
    chk_word("read data", {28'h0, exp}, d);
    chk_word("read resp", {30'h0, gia_pkg::RESP_OKAY}, {30'h0, r});
  endtask : rd_chk
  task automatic wr_chk(input logic [7:0] idx, input logic [31:0] dat);
    host.wr(adr(idx), dat, r);
    chk_word("write resp", {30'h0, gia_pkg::RESP_OKAY}, {30'h0, r});
  endtask : wr_chk
  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // sequence
  // ==========================================================================
  initial
  begin
    {clk_sys, reset_n, src, bad_count, cmp_count, cyc} = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int g = 0; g < 4; g++)
    begin
      rd_chk(sts_idx[g], 4'h0);
      rd_chk(en_idx[g], 4'h0);
    end
    foreach (rows[i])
    begin
      // upper ones in every write must not stick
      for (int g = 0; g < 4; g++)
        wr_chk(en_idx[g], 32'hFFFF_FFF0 | 32'(rows[i].en[g*4 +: 4]));
      src <= rows[i].src;
      repeat (6) @(posedge clk_sys);
      chk_flag("irq", rows[i].irq, irq);
      for (int g = 0; g < 4; g++)
      begin
        rd_chk(sts_idx[g], rows[i].src[g*4 +: 4]);
        rd_chk(en_idx[g], rows[i].en[g*4 +: 4]);
      end
    end
    src <= 16'h5A3C;
    repeat (6) @(posedge clk_sys);
    wr_chk(gia_pkg::HDLC_IRQ_STATUS_IDX, 32'h0);
    rd_chk(gia_pkg::HDLC_IRQ_STATUS_IDX, 4'h5);
    host.rd(12'h3E0, d, r);
    chk_word("unmapped resp", {30'h0, gia_pkg::RESP_SLVERR}, {30'h0, r});
    chk_flag("irq", 1'b1, irq);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_flag("irq after reset", 1'b0, irq);
    for (int g = 0; g < 4; g++)
      rd_chk(en_idx[g], 4'h0);
    // a pulse caught by the sticky edge flag keeps the line up until cleared
    wr_chk(gia_pkg::EDGE_IRQ_STATUS_IDX, 32'h0000FFFF);
    wr_chk(gia_pkg::EDGE_IRQ_ENABLE_IDX, 32'h00000002);
    src <= 16'h5A3E;
    repeat (6) @(posedge clk_sys);
    src <= 16'h5A3C;
    repeat (6) @(posedge clk_sys);
    chk_flag("irq edge held", 1'b1, irq);
    host.rd(adr(gia_pkg::EDGE_IRQ_STATUS_IDX), d, r);
    chk_word("edge status", 32'h00000002, d);
    wr_chk(gia_pkg::EDGE_IRQ_STATUS_IDX, 32'h00000002);
    repeat (2) @(posedge clk_sys);
    chk_flag("irq edge cleared", 1'b0, irq);
    host.rd(adr(gia_pkg::EDGE_IRQ_STATUS_IDX), d, r);
    chk_word("edge status cleared", 32'h00000000, d);
    tally_and_finish();
  end
endmodule : test_global_interrupt_aggregator
